// File: verilog/ptc_top.sv
// periodic tick counter with apb register access
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ptc_cfg.svh"

module ptc_top
  import ptc_pkg::*;
#(
  parameter int ADDR_W = `PTC_ADDR_W,
  parameter int DIV_W = `PTC_DIV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lpo_clk,
  input wire logic ext_ref_clk,
  input wire logic int_ref_clk,
  input wire logic bdm_active,
  output logic tick_irq
);

  // ============================================================
  // helper functions
  function automatic logic [DIV_W-1:0] ptc_divide(input logic src0, input logic [3:0] code);
    logic [DIV_W-1:0] one;
    logic [DIV_W-1:0] val;
    one = DIV_W'(1);
    val = '0;
    if (code == `PTC_DIV_OFF) begin
      val = '0;
    end else if (!code[3]) begin
      if (!src0) begin
        if (code == 4'h1) begin
          val = one << `PTC_LO_EXP1;
        end else begin
          val = one << (code + `PTC_LO_EXP_OFS);
        end
      end else begin
        val = one << (code + `PTC_HI_EXP_OFS);
      end
    end else begin
      unique case ({src0, code[2:0]})
        4'h0: val = `PTC_LO_DEC0;
        4'h1: val = `PTC_LO_DEC1;
        4'h2: val = `PTC_LO_DEC2;
        4'h3: val = `PTC_LO_DEC3;
        4'h4: val = `PTC_LO_DEC4;
        4'h5: val = `PTC_LO_DEC5;
        4'h6: val = `PTC_LO_DEC6;
        4'h7: val = `PTC_LO_DEC7;
        4'h8: val = `PTC_HI_DEC0;
        4'h9: val = `PTC_HI_DEC1;
        4'ha: val = `PTC_HI_DEC2;
        4'hb: val = `PTC_HI_DEC3;
        4'hc: val = `PTC_HI_DEC4;
        4'hd: val = `PTC_HI_DEC5;
        4'he: val = `PTC_HI_DEC6;
        4'hf: val = `PTC_HI_DEC7;
      endcase
    end
    return val;
  endfunction

  function automatic logic ptc_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    return addr == off;
  endfunction

  // ============================================================
  // registers and state
  ptc_byte_t count_reg;
  ptc_byte_t limit_reg;
  ptc_src_t src_reg;
  logic [3:0] div_reg;
  logic flag_reg;
  logic ie_reg;
  logic [2:0] src_prev_reg;
  logic ack_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  logic access;
  logic wr_en;
  logic hit_ctl;
  logic hit_cnt;
  logic hit_lim;
  logic mapped;
  logic wr_ctl;
  logic wr_lim;
  logic src_change;
  logic div_change;
  logic cfg_clear;
  logic [2:0] src_now;
  logic [2:0] src_rise;
  logic sel_edge;
  logic tick;
  logic wrap;
  logic flag_set;
  logic flag_clr;
  ptc_src_t src_wr;
  logic [3:0] div_wr;
  logic [31:0] rd_mux;

  ptc_tick_if #(.DIV_W(DIV_W)) tick_bus ();

  // ============================================================
  // apb decode: one wait state, read data registered
  assign access = psel && penable;
  assign pready = access && ack_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && pready;
  assign wr_en = pready && pwrite;

  assign hit_ctl = ptc_hit(paddr, `PTC_OFF_CTL);
  assign hit_cnt = ptc_hit(paddr, `PTC_OFF_CNT);
  assign hit_lim = ptc_hit(paddr, `PTC_OFF_LIM);
  assign mapped = hit_ctl || hit_cnt || hit_lim;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access && !ack_reg;
    end
  end

  always_comb begin
    rd_mux = '0;
    if (hit_ctl) begin
      rd_mux[`PTC_FLAG_BIT] = flag_reg;
      rd_mux[`PTC_SRC_HI:`PTC_SRC_LO] = src_reg;
      rd_mux[`PTC_IE_BIT] = ie_reg;
      rd_mux[`PTC_DIV_HI:`PTC_DIV_LO] = div_reg;
    end else if (hit_cnt) begin
      rd_mux[7:0] = count_reg;
    end else if (hit_lim) begin
      rd_mux[7:0] = limit_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (access && !ack_reg) begin
      prdata_reg <= pwrite ? '0 : rd_mux;
      pslverr_reg <= !mapped;
    end
  end

  // ============================================================
  // write decode and config-change detection
  assign wr_ctl = wr_en && hit_ctl;
  assign wr_lim = wr_en && hit_lim;
  assign src_wr = ptc_src_t'(pwdata[`PTC_SRC_HI:`PTC_SRC_LO]);
  assign div_wr = pwdata[`PTC_DIV_HI:`PTC_DIV_LO];
  assign src_change = wr_ctl && (src_wr != src_reg);
  assign div_change = wr_ctl && (div_wr != div_reg);
  assign cfg_clear = wr_lim || src_change || div_change;

  // ============================================================
  // control and limit registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= ptc_src_t'(`PTC_SRC_RST);
      div_reg <= `PTC_DIV_RST;
      ie_reg <= 1'b0;
    end else if (wr_ctl) begin
      src_reg <= src_wr;
      div_reg <= div_wr;
      ie_reg <= pwdata[`PTC_IE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_reg <= `PTC_LIM_RST;
    end else if (wr_lim) begin
      limit_reg <= pwdata[7:0];
    end
  end

  // ============================================================
  // source selection: edges taken per source so a switch never fakes one
  assign src_now = {int_ref_clk, ext_ref_clk, lpo_clk};
  assign src_rise = src_now & ~src_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_reg <= '0;
    end else begin
      src_prev_reg <= src_now;
    end
  end

  always_comb begin
    unique case (src_reg)
      PTC_SRC_LPO: sel_edge = src_rise[0];
      PTC_SRC_EXT: sel_edge = src_rise[1];
      PTC_SRC_INT: sel_edge = src_rise[2];
      PTC_SRC_INT_ALT: sel_edge = src_rise[2];
    endcase
  end

  // ============================================================
  // prescaler
  assign tick_bus.src_edge = sel_edge;
  assign tick_bus.clear = cfg_clear;
  assign tick_bus.freeze = bdm_active;
  assign tick_bus.divide = ptc_divide(src_reg[0], div_reg);
  assign tick = tick_bus.tick;

  ptc_prescaler #(.DIV_W(DIV_W)) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .bus(tick_bus)
  );

  // ============================================================
  // main counter; count register has no write path
  assign wrap = tick && (count_reg == limit_reg) && !cfg_clear;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `PTC_CNT_RST;
    end else if (cfg_clear) begin
      count_reg <= `PTC_CNT_RST;
    end else if (tick && !bdm_active) begin
      count_reg <= wrap ? `PTC_CNT_RST : count_reg + 8'h01;
    end
  end

  // ============================================================
  // flag and interrupt request; a set beats a same-cycle clear
  assign flag_set = wrap && !bdm_active;
  assign flag_clr = wr_ctl && pwdata[`PTC_FLAG_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_set || (flag_reg && !flag_clr);
    end
  end

  assign tick_irq = flag_reg && ie_reg;

  // ============================================================
  // checks
  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
    (flag_set && ie_reg && !wr_ctl) |=> tick_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("irq does not follow flag and enable");

  property p_lim_clears;
    @(posedge pclk) disable iff (!presetn)
    wr_lim |=> (count_reg == `PTC_CNT_RST) && (limit_reg == $past(pwdata[7:0]));
  endproperty
  a_lim_clears: assert property (p_lim_clears)
    else $error("limit write did not clear count");

  property p_src_clears;
    @(posedge pclk) disable iff (!presetn)
    src_change |=> (count_reg == `PTC_CNT_RST) && !tick;
  endproperty
  a_src_clears: assert property (p_src_clears)
    else $error("source change did not clear count");

  property p_div_clears;
    @(posedge pclk) disable iff (!presetn)
    div_change |=> (count_reg == `PTC_CNT_RST) && !tick;
  endproperty
  a_div_clears: assert property (p_div_clears)
    else $error("divider change did not clear count");

  property p_wrap_flag;
    @(posedge pclk) disable iff (!presetn)
    (tick && !bdm_active && !cfg_clear && count_reg == limit_reg)
      |=> flag_reg && count_reg == `PTC_CNT_RST;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap did not set flag");

  property p_no_early_flag;
    @(posedge pclk) disable iff (!presetn)
    (!flag_reg && !(tick && count_reg == limit_reg)) |=> !flag_reg;
  endproperty
  a_no_early_flag: assert property (p_no_early_flag)
    else $error("flag set without wrap");

  property p_step;
    @(posedge pclk) disable iff (!presetn)
    (tick && !bdm_active && !cfg_clear && count_reg != limit_reg)
      |=> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step by one");

  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
    (bdm_active && !cfg_clear) |=> $stable(count_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("count moved during debug");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
    (flag_clr && !flag_set) |=> !flag_reg && !tick_irq;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  property p_w0_keeps;
    @(posedge pclk) disable iff (!presetn)
    (flag_reg && wr_ctl && !pwdata[`PTC_FLAG_BIT]) |=> flag_reg;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps)
    else $error("write zero changed flag");

  property p_cnt_ro;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit_cnt && !tick) |=> $stable(count_reg);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro)
    else $error("count register took a write");

  property p_off_stays;
    @(posedge pclk) disable iff (!presetn)
    (div_reg == `PTC_DIV_OFF && !cfg_clear) |=> $stable(count_reg) && !tick;
  endproperty
  a_off_stays: assert property (p_off_stays)
    else $error("counting while prescaler off");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not after one wait state");

endmodule

`default_nettype wire

// File: verilog/ptc_cfg.svh
// register map, field positions, reset values and divide constants
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

`define PTC_ADDR_W 12
`define PTC_OFF_CTL 12'h000
`define PTC_OFF_CNT 12'h004
`define PTC_OFF_LIM 12'h008

`define PTC_FLAG_BIT 7
`define PTC_SRC_HI 6
`define PTC_SRC_LO 5
`define PTC_IE_BIT 4
`define PTC_DIV_HI 3
`define PTC_DIV_LO 0

`define PTC_CNT_RST 8'h00
`define PTC_LIM_RST 8'h00
`define PTC_SRC_RST 2'h0
`define PTC_DIV_RST 4'h0
`define PTC_DIV_OFF 4'h0

`define PTC_DIV_W 18
`define PTC_LO_EXP1 3
`define PTC_LO_EXP_OFS 3
`define PTC_HI_EXP_OFS 9

`define PTC_LO_DEC0 18'd1
`define PTC_LO_DEC1 18'd2
`define PTC_LO_DEC2 18'd4
`define PTC_LO_DEC3 18'd10
`define PTC_LO_DEC4 18'd16
`define PTC_LO_DEC5 18'd100
`define PTC_LO_DEC6 18'd500
`define PTC_LO_DEC7 18'd1000
`define PTC_HI_DEC0 18'd1000
`define PTC_HI_DEC1 18'd2000
`define PTC_HI_DEC2 18'd5000
`define PTC_HI_DEC3 18'd10000
`define PTC_HI_DEC4 18'd20000
`define PTC_HI_DEC5 18'd50000
`define PTC_HI_DEC6 18'd100000
`define PTC_HI_DEC7 18'd200000

`endif

// File: verilog/ptc_pkg.sv
// shared types of the periodic tick counter
package ptc_pkg;

  typedef logic [7:0] ptc_byte_t;

  typedef enum logic [1:0] {
    PTC_SRC_LPO = 2'b00,
    PTC_SRC_EXT = 2'b01,
    PTC_SRC_INT = 2'b10,
    PTC_SRC_INT_ALT = 2'b11
  } ptc_src_t;

endpackage

// File: verilog/ptc_tick_if.sv
// link between the register block and the prescaler
`timescale 1ns/10ps
`default_nettype none

interface ptc_tick_if #(parameter int DIV_W = 18);
  logic src_edge;
  logic clear;
  logic freeze;
  logic [DIV_W-1:0] divide;
  logic tick;

  modport ctrl (output src_edge, output clear, output freeze, output divide, input tick);
  modport presc (input src_edge, input clear, input freeze, input divide, output tick);
endinterface

`default_nettype wire

// File: verilog/ptc_prescaler.sv
// prescaler: divides selected source edges into one-cycle ticks
`timescale 1ns/10ps
`default_nettype none
`include "ptc_cfg.svh"

module ptc_prescaler #(
  parameter int DIV_W = `PTC_DIV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  ptc_tick_if.presc bus
);

  logic [DIV_W-1:0] pre_cnt_reg;
  logic tick_reg;
  logic running;
  logic last;

  // divide value zero means off
  assign running = (bus.divide != '0) && !bus.freeze;
  assign last = (pre_cnt_reg == bus.divide - DIV_W'(1));

  // ============================================================
  // divider count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= '0;
    end else if (bus.clear) begin
      pre_cnt_reg <= '0;
    end else if (running && bus.src_edge) begin
      pre_cnt_reg <= last ? '0 : pre_cnt_reg + DIV_W'(1);
    end
  end

  // ============================================================
  // output tick, one cycle per divided period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= !bus.clear && running && bus.src_edge && last;
    end
  end

  assign bus.tick = tick_reg;

  property p_off_no_tick;
    @(posedge pclk) disable iff (!presetn)
    (bus.divide == '0) |=> !tick_reg;
  endproperty
  a_off_no_tick: assert property (p_off_no_tick)
    else $error("prescaler ticked while off");

endmodule

`default_nettype wire

// File: verif/ptc_tb.sv
// self-checking testbench of the periodic tick counter
`timescale 1ns/10ps
`default_nettype none
`include "ptc_cfg.svh"

module testbench;
  import ptc_pkg::*;

  typedef struct {
    logic [1:0] src;
    logic [3:0] dv;
    logic [7:0] lim;
    int n;
    logic [7:0] cnt;
    logic flag;
  } ptc_row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] src_lvl = 3'h0;
  logic bdm = 1'b0;
  logic tick_irq;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  ptc_row_t rows[14];

  always #4 pclk = ~pclk;

  ptc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lpo_clk(src_lvl[0]), .ext_ref_clk(src_lvl[1]),
    .int_ref_clk(src_lvl[2]), .bdm_active(bdm), .tick_irq(tick_irq));

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      $display("Error at %0t: run too long", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; pready, read data and error taken at the rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // irq is a level output; looked at once the last edge's updates have settled
  task automatic ichk(input logic exp, input string what);
    @(negedge pclk);
    chk({31'h0, tick_irq}, {31'h0, exp}, what);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, {24'h0, d}, rd, er);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, {24'h0, exp}, what);
    chk({31'h0, er}, 32'h0, "pslverr");
  endtask

  // source edges, each level held two bus cycles
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge pclk);
      src_lvl[s] <= 1'b1;
      repeat (2) @(posedge pclk);
      src_lvl[s] <= 1'b0;
      @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask

  function automatic int sidx(input logic [1:0] s);
    return (s == 2'b00) ? 0 : ((s == 2'b01) ? 1 : 2);
  endfunction

  initial begin
    logic [31:0] rd;
    logic er;
    int s;
    rows = '{'{2'h0, 4'h8, 8'h02, 3, 8'h00, 1'b1}, '{2'h0, 4'h9, 8'hff, 6, 8'h03, 1'b0},
      '{2'h0, 4'ha, 8'hff, 8, 8'h02, 1'b0}, '{2'h0, 4'hb, 8'hff, 20, 8'h02, 1'b0},
      '{2'h0, 4'hc, 8'hff, 32, 8'h02, 1'b0}, '{2'h0, 4'h1, 8'hff, 16, 8'h02, 1'b0},
      '{2'h0, 4'h2, 8'hff, 64, 8'h02, 1'b0}, '{2'h1, 4'h1, 8'hff, 1024, 8'h01, 1'b0},
      '{2'h1, 4'h8, 8'hff, 1000, 8'h01, 1'b0}, '{2'h2, 4'h8, 8'hff, 5, 8'h05, 1'b0},
      '{2'h3, 4'h8, 8'hff, 1000, 8'h01, 1'b0}, '{2'h0, 4'h8, 8'h00, 1, 8'h00, 1'b1},
      '{2'h0, 4'h8, 8'hff, 256, 8'h00, 1'b1}, '{2'h0, 4'hd, 8'hff, 200, 8'h02, 1'b0}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // ================================
    // table of divide ratios, sources and limits
    for (int i = 0; i < 14; i++) begin
      s = sidx(rows[i].src);
      wr(`PTC_OFF_CTL, {1'b1, rows[i].src, 1'b0, rows[i].dv});
      wr(`PTC_OFF_LIM, rows[i].lim);
      pulse(s, rows[i].n);
      rchk(`PTC_OFF_CNT, rows[i].cnt, "row count");
      rchk(`PTC_OFF_CTL, {rows[i].flag, rows[i].src, 1'b0, rows[i].dv}, "row flag");
      pulse((s + 1) % 3, 2);
      pulse((s + 2) % 3, 2);
      rchk(`PTC_OFF_CNT, rows[i].cnt, "other sources");
    end
    // ================================
    // flag, interrupt and write-one clear
    wr(`PTC_OFF_CTL, 8'h98);
    wr(`PTC_OFF_LIM, 8'h03);
    pulse(0, 3);
    rchk(`PTC_OFF_CTL, 8'h18, "flag early");
    ichk(1'b0, "irq early");
    pulse(0, 1);
    rchk(`PTC_OFF_CTL, 8'h98, "flag at wrap");
    ichk(1'b1, "irq set");
    wr(`PTC_OFF_CTL, 8'h18);
    rchk(`PTC_OFF_CTL, 8'h98, "zero write");
    wr(`PTC_OFF_CTL, 8'h98);
    rchk(`PTC_OFF_CTL, 8'h18, "one write");
    ichk(1'b0, "irq cleared");
    pulse(0, 4);
    wr(`PTC_OFF_CTL, 8'h08);
    ichk(1'b0, "irq masked");
    // ================================
    // divider off, debug freeze, config clears
    wr(`PTC_OFF_CTL, 8'h80);
    pulse(0, 3);
    rchk(`PTC_OFF_CNT, 8'h00, "divider off");
    wr(`PTC_OFF_CTL, 8'h08);
    wr(`PTC_OFF_LIM, 8'hff);
    pulse(0, 2);
    @(posedge pclk);
    bdm <= 1'b1;
    pulse(0, 3);
    rchk(`PTC_OFF_CNT, 8'h02, "frozen");
    bdm <= 1'b0;
    pulse(0, 1);
    rchk(`PTC_OFF_CNT, 8'h03, "resumed");
    wr(`PTC_OFF_CTL, 8'h08);
    rchk(`PTC_OFF_CNT, 8'h03, "same config");
    wr(`PTC_OFF_CTL, 8'h09);
    rchk(`PTC_OFF_CNT, 8'h00, "divider change");
    pulse(0, 1);
    wr(`PTC_OFF_LIM, 8'hff);
    pulse(0, 1);
    rchk(`PTC_OFF_CNT, 8'h00, "prescaler cleared");
    pulse(0, 2);
    wr(`PTC_OFF_CNT, 8'h55);
    rchk(`PTC_OFF_CNT, 8'h01, "count read only");
    wr(`PTC_OFF_CTL, 8'h29);
    rchk(`PTC_OFF_CNT, 8'h00, "source change");
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h1, "unmapped");
    // ================================
    // reset in mid run
    wr(`PTC_OFF_CTL, 8'h98);
    wr(`PTC_OFF_LIM, 8'h05);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    ichk(1'b0, "irq reset");
    rchk(`PTC_OFF_CTL, 8'h00, "ctl reset");
    rchk(`PTC_OFF_LIM, 8'h00, "limit reset");
    pulse(0, 4);
    rchk(`PTC_OFF_CNT, 8'h00, "stopped");
    summarize();
  end
endmodule

`default_nettype wire
